// file: design/gmcd_defs.vh
`ifndef GMCD_DEFS_VH
`define GMCD_DEFS_VH

// ---------------------------------------------
// Address byte layout
// ---------------------------------------------
`define GMCD_ADDR_FIX_HI 3'h4
`define GMCD_ADDR_FIX_LO 2'h0
`define GMCD_ADDR_SEL_BIT 4
`define GMCD_ADDR_BCAST_BIT 3
`define GMCD_ADDR_CLASS_BIT 0
`define GMCD_ADDR_ID_CH1 8'h80
`define GMCD_ADDR_ID_CH2 8'h90
`define GMCD_CMD_IDENTIFY 8'h00
`define GMCD_CONFIG_NIBBLE 4'h0

// ---------------------------------------------
// Opcodes
// ---------------------------------------------
`define GMCD_OP_READ_REV 8'h73
`define GMCD_OP_DEACTIVATE 8'h00
`define GMCD_OP_SW_RESET 8'h02
`define GMCD_OP_HW_RESET 8'h04
`define GMCD_OP_ACTIVATE 8'h0E
`define GMCD_OP_CFG1_WR 8'h70
`define GMCD_OP_CFG2_WR 8'h46
`define GMCD_OP_CFG3_WR 8'h60
`define GMCD_OP_LINEIO_WR 8'h54
`define GMCD_OP_MODE_WR 8'h4A
`define GMCD_OP_LINEIO_RD 8'h53
`define GMCD_OP_DEBOUNCE_WR 8'hC8
`define GMCD_OP_GKFILT_WR 8'hE8
`define GMCD_OP_RTDATA_RD_A 8'h4D
`define GMCD_OP_RTDATA_RD_B 8'h4F
`define GMCD_OP_IMASK_WR 8'h6C
`define GMCD_OP_SCALE_WR 8'h50
`define GMCD_OP_TXGAIN_WR 8'h80
`define GMCD_OP_RXGAIN_WR 8'h82
`define GMCD_OP_ZFIR_WR 8'h98
`define GMCD_OP_BFIR_WR 8'h86
`define GMCD_OP_XCORR_WR 8'h88
`define GMCD_OP_RCORR_WR 8'h8A
`define GMCD_OP_BIIR_WR 8'h96
`define GMCD_OP_ZIIR_WR 8'h9A

// Opcode classes
`define GMCD_CLS_NONE 3'h0
`define GMCD_CLS_STATUS 3'h1
`define GMCD_CLS_WRITE 3'h2
`define GMCD_CLS_READ 3'h3
`define GMCD_CLS_REV 3'h4

// ---------------------------------------------
// Message and frame figures
// ---------------------------------------------
`define GMCD_MAX_BYTES 4'hE
`define GMCD_EOM_FRAMES 2'h2
`define GMCD_FRAME_US 125
`define GMCD_SLOT_BITS 32
`define GMCD_MON_FIRST_BIT 16
`define GMCD_SC_LAST_BIT 31

`endif

// file: design/gmcd_link.v
`default_nettype none

// Slot engine: pulls the monitor and handshake bits of one GCI channel
// slot off the downstream line and drives the same bits upstream.
module gmcd_link #(
    parameter SLOT = 0,
    parameter FRAME_BITS = 256
) (
    input wire ref_clk,
    input wire rst_n,
    input wire dcl,
    input wire fsc,
    input wire dd,
    output reg du_out,
    output reg du_oe,
    output reg frame_tick,
    output reg [7:0] rx_mon,
    output reg rx_mr,
    output reg rx_mx,
    input wire [7:0] tx_mon,
    input wire tx_mr,
    input wire tx_mx
);

`include "gmcd_defs.vh"

localparam integer BASE_I = SLOT * `GMCD_SLOT_BITS; // Full width before the cut
localparam integer LAST_I = FRAME_BITS - 1;
localparam [8:0] BASE = BASE_I[8:0];
localparam [8:0] LAST_POS = LAST_I[8:0];

// ---------------------------------------------
// Pin synchronisers
// ---------------------------------------------
reg dcl_s1, dcl_s2, dcl_s3; // Third stage only for edge finding
reg fsc_s1, fsc_s2;
reg dd_s1, dd_s2;

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        dcl_s1 <= 1'b0;
        dcl_s2 <= 1'b0;
        dcl_s3 <= 1'b0;
        fsc_s1 <= 1'b0;
        fsc_s2 <= 1'b0;
        dd_s1 <= 1'b1;
        dd_s2 <= 1'b1;
    end else begin
        dcl_s1 <= dcl;
        dcl_s2 <= dcl_s1;
        dcl_s3 <= dcl_s2;
        fsc_s1 <= fsc;
        fsc_s2 <= fsc_s1;
        dd_s1 <= dd;
        dd_s2 <= dd_s1;
    end
end

wire dcl_fall = dcl_s3 & ~dcl_s2; // Data sampled here
wire dcl_rise = ~dcl_s3 & dcl_s2; // Data launched here

// ---------------------------------------------
// Bit position and slot capture
// ---------------------------------------------
reg [8:0] bit_cnt; // Position of the bit now on the line
reg [15:0] rx_sh; // Monitor byte then SC byte
reg [15:0] tx_word; // Upstream monitor and SC bytes
wire [8:0] pos = fsc_s2 ? 9'h000 : bit_cnt;
wire [8:0] off = pos - BASE;
wire [8:0] nxt_off = bit_cnt - BASE;
wire [15:0] rx_next = {rx_sh[14:0], dd_s2};

// Each monitor byte rides in the third slot byte, once per frame
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        bit_cnt <= 9'h000;
        rx_sh <= 16'hFFFF;
        frame_tick <= 1'b0;
        rx_mon <= 8'hFF;
        rx_mr <= 1'b1;
        rx_mx <= 1'b1;
        tx_word <= 16'hFFFF;
        du_out <= 1'b1;
        du_oe <= 1'b0;
    end else begin
        frame_tick <= 1'b0;
        if (dcl_fall) begin
            bit_cnt <= (pos == LAST_POS) ? 9'h000 : pos + 9'h001;
            if (off >= `GMCD_MON_FIRST_BIT && off <= `GMCD_SC_LAST_BIT) begin
                rx_sh <= rx_next;
            end
            // Whole slot seen: hand over and latch next upstream word
            if (off == `GMCD_SC_LAST_BIT) begin
                frame_tick <= 1'b1;
                rx_mon <= rx_next[15:8];
                rx_mr <= rx_next[1];
                rx_mx <= rx_next[0];
                tx_word <= {tx_mon, 6'h3F, tx_mr, tx_mx};
            end
        end
        if (dcl_rise) begin
            if (nxt_off >= `GMCD_MON_FIRST_BIT && nxt_off <= `GMCD_SC_LAST_BIT) begin
                du_oe <= 1'b1;
                du_out <= tx_word[4'hF - nxt_off[3:0]];
            end else begin
                du_oe <= 1'b0;
                du_out <= 1'b1;
            end
        end
    end
end

endmodule // gmcd_link

`default_nettype wire

// file: design/gmcd_decoder.v
`default_nettype none

// Notes on behaviour
// - Address byte fixed bits 100xx00x checked
// - Select bit names channel one or two
// - Broadcast bit addresses both channels
// - Class bit zero means identification address
// - Read reply is at most fourteen bytes
// - Identify only for address 80h/90h, cmd 00h
// - Reply byte one: 100, select, 0000
// - Reply byte two: type field, fixed pattern
// - End of message: transmit bit high twice
// - Addresses 81/89/91/99h decode operation commands
// - Opcode 73h returns revision code, no side-effect
// - Status opcodes 00/02/04/0Eh, no data
// - Config registers one to three opcode pairs
// - Line I/O, mode pairs, 53h read only
// - Debounce, ground key, interrupt mask pairs
// - 4D/4Fh read real-time data
// - Scaling, transmit and receive gain pairs
// - Remaining filter coefficient opcode pairs
// - Byte accepted after two equal frames
// - Transmit bit idle two frames ends message
// - Monitor byte third slot byte per frame
module gmcd_decoder #(
    parameter SLOT = 0,
    parameter FRAME_BITS = 256,
    parameter [7:0] REVISION_CODE = 8'h5C, // Arbitrary value
    parameter [1:0] DEVICE_TYPE = 2'h3, // Arbitrary value
    parameter [5:0] ID_PATTERN = 6'h2A // Arbitrary value
) (
    input wire ref_clk,
    input wire rst_n,
    input wire dcl,
    input wire fsc,
    input wire dd,
    output wire du_out,
    output wire du_oe,
    output reg cmd_strobe,
    output reg [7:0] cmd_opcode,
    output reg [1:0] cmd_chan_mask,
    output reg wr_strobe,
    output reg [7:0] wr_byte,
    output reg [3:0] wr_index,
    output reg rd_req,
    input wire [111:0] rd_data,
    input wire [3:0] rd_len,
    output reg busy
);

`include "gmcd_defs.vh"

// ---------------------------------------------
// Opcode classifier
// ---------------------------------------------
function [2:0] op_class;
    input [7:0] op;
    begin
        case (op)
            `GMCD_OP_READ_REV: op_class = `GMCD_CLS_REV;
            `GMCD_OP_DEACTIVATE, `GMCD_OP_SW_RESET,
            `GMCD_OP_HW_RESET, `GMCD_OP_ACTIVATE: op_class = `GMCD_CLS_STATUS;
            `GMCD_OP_CFG1_WR, `GMCD_OP_CFG2_WR, `GMCD_OP_CFG3_WR,
            `GMCD_OP_LINEIO_WR, `GMCD_OP_MODE_WR,
            `GMCD_OP_DEBOUNCE_WR, `GMCD_OP_GKFILT_WR, `GMCD_OP_IMASK_WR,
            `GMCD_OP_SCALE_WR, `GMCD_OP_TXGAIN_WR, `GMCD_OP_RXGAIN_WR,
            `GMCD_OP_ZFIR_WR, `GMCD_OP_BFIR_WR, `GMCD_OP_XCORR_WR,
            `GMCD_OP_RCORR_WR, `GMCD_OP_BIIR_WR, `GMCD_OP_ZIIR_WR:
                op_class = `GMCD_CLS_WRITE;
            `GMCD_OP_CFG1_WR + 8'h01, `GMCD_OP_CFG2_WR + 8'h01,
            `GMCD_OP_CFG3_WR + 8'h01, `GMCD_OP_LINEIO_WR + 8'h01,
            `GMCD_OP_MODE_WR + 8'h01, `GMCD_OP_LINEIO_RD,
            `GMCD_OP_DEBOUNCE_WR + 8'h01, `GMCD_OP_GKFILT_WR + 8'h01,
            `GMCD_OP_IMASK_WR + 8'h01, `GMCD_OP_RTDATA_RD_A,
            `GMCD_OP_RTDATA_RD_B,
            `GMCD_OP_SCALE_WR + 8'h01, `GMCD_OP_TXGAIN_WR + 8'h01,
            `GMCD_OP_RXGAIN_WR + 8'h01, `GMCD_OP_ZFIR_WR + 8'h01,
            `GMCD_OP_BFIR_WR + 8'h01, `GMCD_OP_XCORR_WR + 8'h01,
            `GMCD_OP_RCORR_WR + 8'h01, `GMCD_OP_BIIR_WR + 8'h01,
            `GMCD_OP_ZIIR_WR + 8'h01:
                op_class = `GMCD_CLS_READ;
            default: op_class = `GMCD_CLS_NONE; // Unknown opcode
        endcase
    end
endfunction

// ---------------------------------------------
// States
// ---------------------------------------------
localparam [2:0] S_ADDR = 3'h0; // Waiting for address byte
localparam [2:0] S_CMD = 3'h1; // Waiting for command byte
localparam [2:0] S_WDATA = 3'h2; // Collecting write data
localparam [2:0] S_RDWAIT = 3'h3; // One cycle for read data
localparam [2:0] S_TX = 3'h4; // Sending reply bytes
localparam [2:0] S_EOMTX = 3'h5; // Sending end of message
localparam [2:0] S_WAITEOM = 3'h6; // Waiting for far end idle

// ---------------------------------------------
// Link slot engine
// ---------------------------------------------
wire frame_tick; // One pulse per frame, after our slot
wire [7:0] rx_mon; // Downstream monitor byte
wire rx_mr; // Far end acknowledge, unused by fixed pacing
wire rx_mx; // Far end transmit bit, active low
reg [7:0] tx_mon; // Upstream monitor byte
reg tx_mr; // Our acknowledge, active low
reg tx_mx; // Our transmit bit, active low

gmcd_link #(
    .SLOT(SLOT),
    .FRAME_BITS(FRAME_BITS)
) u_link (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .dcl(dcl),
    .fsc(fsc),
    .dd(dd),
    .du_out(du_out),
    .du_oe(du_oe),
    .frame_tick(frame_tick),
    .rx_mon(rx_mon),
    .rx_mr(rx_mr),
    .rx_mx(rx_mx),
    .tx_mon(tx_mon),
    .tx_mr(tx_mr),
    .tx_mx(tx_mx)
);

// ---------------------------------------------
// Receive byte acceptance and idle detection
// ---------------------------------------------
reg [7:0] prev_mon; // Byte seen in the previous frame
reg prev_act; // Previous frame carried an active transmit bit
reg taken; // Current repeated byte already accepted
reg [1:0] idle_cnt; // Frames with transmit bit idle
reg byte_ok; // Pulse: new byte accepted
reg [7:0] byte_val; // Accepted byte
wire rx_idle = (idle_cnt >= `GMCD_EOM_FRAMES);

// Repeats of the same byte are only accepted once; equal consecutive
// bytes need an idle frame or a different byte between them.
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        prev_mon <= 8'hFF;
        prev_act <= 1'b0;
        taken <= 1'b0;
        idle_cnt <= 2'h2;
        byte_ok <= 1'b0;
        byte_val <= 8'h00;
    end else begin
        byte_ok <= 1'b0;
        if (frame_tick) begin
            prev_mon <= rx_mon;
            prev_act <= ~rx_mx;
            if (rx_mx) begin
                // Both idle frames count toward end of message
                if (idle_cnt != `GMCD_EOM_FRAMES) begin
                    idle_cnt <= idle_cnt + 2'h1;
                end
                taken <= 1'b0;
            end else begin
                idle_cnt <= 2'h0;
                if (rx_mon != prev_mon) begin
                    taken <= 1'b0;
                end else if (prev_act && !taken) begin
                    byte_ok <= 1'b1; // Same byte twice in a row
                    byte_val <= rx_mon;
                    taken <= 1'b1;
                end
            end
        end
    end
end

// ---------------------------------------------
// Message state machine
// ---------------------------------------------
reg [2:0] state;
reg [7:0] addr; // Latched address byte
reg [7:0] rbuf [0:13]; // Reply bytes
reg [3:0] tx_len; // Reply length
reg [3:0] tx_idx; // Reply byte being sent
reg [1:0] frm_cnt; // Frames spent on current byte or end
wire addr_ok = (byte_val[7:5] == `GMCD_ADDR_FIX_HI) &&
               (byte_val[2:1] == `GMCD_ADDR_FIX_LO);
wire [2:0] cls = op_class(byte_val);
wire a_sel = addr[`GMCD_ADDR_SEL_BIT];
wire [3:0] clamp_len = (rd_len > `GMCD_MAX_BYTES) ? `GMCD_MAX_BYTES :
                       (rd_len == 4'h0) ? 4'h1 : rd_len;
integer i;

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        state <= S_ADDR;
        addr <= 8'h00;
        tx_len <= 4'h0;
        tx_idx <= 4'h0;
        frm_cnt <= 2'h0;
        tx_mon <= 8'hFF;
        tx_mr <= 1'b1;
        tx_mx <= 1'b1;
        cmd_strobe <= 1'b0;
        cmd_opcode <= 8'h00;
        cmd_chan_mask <= 2'h0;
        wr_strobe <= 1'b0;
        wr_byte <= 8'h00;
        wr_index <= 4'h0;
        rd_req <= 1'b0;
        busy <= 1'b0;
        for (i = 0; i < 14; i = i + 1) begin
            rbuf[i] <= 8'hFF;
        end
    end else begin
        cmd_strobe <= 1'b0;
        wr_strobe <= 1'b0;
        rd_req <= 1'b0;
        // Acknowledge each accepted byte for one frame
        if (byte_ok) begin
            tx_mr <= 1'b0;
        end else if (frame_tick) begin
            tx_mr <= 1'b1;
        end
        busy <= (state != S_ADDR);
        case (state)
            S_ADDR: begin
                if (byte_ok) begin
                    addr <= byte_val;
                    // Broadcast reaches both, else only the selected one
                    if (byte_val[`GMCD_ADDR_BCAST_BIT]) begin
                        cmd_chan_mask <= 2'h3;
                    end else begin
                        cmd_chan_mask <= byte_val[`GMCD_ADDR_SEL_BIT] ? 2'h2 : 2'h1;
                    end
                    // Nonconforming address: drop the whole message
                    state <= addr_ok ? S_CMD : S_WAITEOM;
                end
            end
            S_CMD: begin
                if (rx_idle) begin
                    state <= S_ADDR; // Message ended early
                end else if (byte_ok) begin
                    cmd_opcode <= byte_val;
                    if (!addr[`GMCD_ADDR_CLASS_BIT]) begin
                        // Identification class address
                        if ((addr == `GMCD_ADDR_ID_CH1 || addr == `GMCD_ADDR_ID_CH2) &&
                            byte_val == `GMCD_CMD_IDENTIFY) begin
                            rbuf[0] <= {`GMCD_ADDR_FIX_HI, a_sel,
                                        `GMCD_CONFIG_NIBBLE};
                            rbuf[1] <= {DEVICE_TYPE, ID_PATTERN};
                            tx_len <= 4'h2;
                            tx_idx <= 4'h0;
                            frm_cnt <= 2'h0;
                            state <= S_TX;
                        end else begin
                            state <= S_WAITEOM;
                        end
                    end else begin
                        // Operation class address
                        case (cls)
                            `GMCD_CLS_REV: begin
                                rbuf[0] <= REVISION_CODE; // No state touched
                                tx_len <= 4'h1;
                                tx_idx <= 4'h0;
                                frm_cnt <= 2'h0;
                                state <= S_TX;
                            end
                            `GMCD_CLS_STATUS: begin
                                cmd_strobe <= 1'b1; // No data follows
                                state <= S_WAITEOM;
                            end
                            `GMCD_CLS_WRITE: begin
                                cmd_strobe <= 1'b1;
                                wr_index <= 4'h0;
                                state <= S_WDATA;
                            end
                            `GMCD_CLS_READ: begin
                                cmd_strobe <= 1'b1;
                                rd_req <= 1'b1;
                                state <= S_RDWAIT;
                            end
                            default: begin
                                state <= S_WAITEOM; // Unknown opcode
                            end
                        endcase
                    end
                end
            end
            S_WDATA: begin
                // Data bytes until the controller ends the message
                if (rx_idle) begin
                    state <= S_ADDR;
                end else if (byte_ok) begin
                    if (wr_index < `GMCD_MAX_BYTES) begin
                        wr_strobe <= 1'b1;
                        wr_byte <= byte_val;
                        wr_index <= wr_index + 4'h1;
                    end
                end
            end
            S_RDWAIT: begin
                // User answers the read one cycle after the request
                for (i = 0; i < 14; i = i + 1) begin
                    rbuf[i] <= rd_data[i * 8 +: 8];
                end
                tx_len <= clamp_len;
                tx_idx <= 4'h0;
                frm_cnt <= 2'h0;
                state <= S_TX;
            end
            S_TX: begin
                tx_mon <= rbuf[tx_idx];
                tx_mx <= 1'b0;
                // Each byte repeats for two frames, so the far end sees it twice
                if (frame_tick) begin
                    if (frm_cnt == 2'h1) begin
                        frm_cnt <= 2'h0;
                        if (tx_idx == tx_len - 4'h1) begin
                            state <= S_EOMTX;
                        end else begin
                            tx_idx <= tx_idx + 4'h1;
                        end
                    end else begin
                        frm_cnt <= frm_cnt + 2'h1;
                    end
                end
            end
            S_EOMTX: begin
                // Transmit bit held idle for two frames closes reply
                tx_mx <= 1'b1;
                tx_mon <= 8'hFF;
                if (frame_tick) begin
                    if (frm_cnt == `GMCD_EOM_FRAMES - 2'h1) begin
                        frm_cnt <= 2'h0;
                        state <= S_WAITEOM;
                    end else begin
                        frm_cnt <= frm_cnt + 2'h1;
                    end
                end
            end
            S_WAITEOM: begin
                // Next message only after far end idles
                if (rx_idle) begin
                    state <= S_ADDR;
                end
            end
            default: begin
                state <= S_ADDR;
            end
        endcase
    end
end

endmodule // gmcd_decoder

`default_nettype wire

// file: verif/gmcd_decoder_sva.sv
`default_nettype none
// ------------------------------
// Port checker for the decoder
// ------------------------------
module gmcd_decoder_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic du_out,
    input wire logic du_oe,
    input wire logic cmd_strobe,
    input wire logic [7:0] cmd_opcode,
    input wire logic [1:0] cmd_chan_mask,
    input wire logic wr_strobe,
    input wire logic [3:0] wr_index,
    input wire logic rd_req,
    input wire logic busy
);
    // One domain, so one clock and one reset for all
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    property p_cmd_pulse;
        cmd_strobe |=> !cmd_strobe;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("long command strobe");
    property p_rd_once;
        rd_req |-> cmd_strobe ##1 !rd_req;
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("bad read request");
    property p_rd_odd;
        rd_req |-> cmd_opcode[0];
    endproperty
    a_rd_odd: assert property (p_rd_odd) else $error("read on even opcode");
    property p_wr_even;
        wr_strobe |-> !cmd_opcode[0];
    endproperty
    a_wr_even: assert property (p_wr_even) else $error("write on odd opcode");
    // Status opcodes never carry data bytes
    property p_status_nodata;
        wr_strobe |-> !(cmd_opcode inside {8'h00, 8'h02, 8'h04, 8'h0E});
    endproperty
    a_status_nodata: assert property (p_status_nodata) else $error("status data");
    property p_wr_count;
        wr_strobe |-> wr_index >= 4'h1 && wr_index <= 4'hE;
    endproperty
    a_wr_count: assert property (p_wr_count) else $error("write index range");
    property p_mask;
        cmd_strobe |-> cmd_chan_mask != 2'h0 && busy;
    endproperty
    a_mask: assert property (p_mask) else $error("empty channel mask");
    property p_release;
        !du_oe |-> du_out;
    endproperty
    a_release: assert property (p_release) else $error("released line low");
    // Monitor plus handshake bits: sixteen link bits of 16 cycles
    property p_oe_slot;
        $rose(du_oe) |-> ##250 du_oe ##[1:12] !du_oe;
    endproperty
    a_oe_slot: assert property (p_oe_slot) else $error("drive window length");
    c_cmd: cover property (cmd_strobe);
    c_wr: cover property (wr_strobe && wr_index == 4'hE);
    c_rd: cover property (rd_req);
endmodule // gmcd_decoder_sva
`default_nettype wire

// file: verif/gmcd_host.sv
`default_nettype none
// ------------------------------
// Highway controller model
// ------------------------------
module gmcd_host (
    output logic dcl,
    output logic fsc,
    output logic dd,
    input wire logic du_out,
    input wire logic du_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] bitn = 5'h1F; // Bit now on the line
    logic [4:0] nb; // Bit about to launch
    logic [7:0] tx_b = 8'hFF; // Byte for the next frame
    logic [7:0] cur_b = 8'hFF; // Byte of this frame
    logic tx_mx = 1'b1;
    logic cur_mx = 1'b1;
    logic up_mx = 1'b1; // Upstream transmit bit, last frame
    logic [31:0] word; // Downstream slot, first bit highest
    logic [31:0] sh; // Upstream slot as it arrives
    logic [7:0] up_q[$]; // One entry per upstream frame with a byte
    int eom_n = 0; // Idle upstream frames in a row
    event fstart;
    // Free running bit clock, phase unrelated to ref_clk
    initial begin
        dcl = 1'b0;
        #3;
        forever #80 dcl = ~dcl;
    end
    // Launch on rising edge; receive bit acks last frame's byte
    always @(posedge dcl) begin
        nb = bitn + 5'h01;
        word = {16'hFFFF, cur_b, 6'h3F, up_mx, cur_mx};
        fsc <= (nb == 5'h00);
        dd <= word[~nb]; // Most significant bit first
        bitn <= nb;
        if (nb == 5'h1F) begin
            cur_b <= tx_b;
            cur_mx <= tx_mx;
            -> fstart;
        end
    end
    // Released line reads high through its pull-up
    always @(negedge dcl) begin
        sh = {sh[30:0], du_oe ? du_out : 1'b1};
        if (bitn == 5'h1F) begin
            up_mx <= sh[0];
            eom_n <= sh[0] ? eom_n + 1 : 0;
            if (sh[0] == 1'b0)
                up_q.push_back(sh[15:8]);
        end
    end
    task automatic frame(input logic [7:0] b, input logic mx);
        tx_b = b;
        tx_mx = mx;
        @(fstart);
    endtask
    // Each byte twice so the far receiver accepts it
    task automatic msg(input logic [7:0] m[20], input int n, input int idle);
        for (int i = 0; i < 2 * n; i++)
            frame(m[i / 2], 1'b0);
        for (int i = 0; i < idle; i++)
            frame(8'hFF, 1'b1); // Idle ends the message
    endtask
endmodule // gmcd_host
`default_nettype wire

// file: verif/gmcd_decoder_test.sv
`default_nettype none
// ------------------------------
// Decoder bench
// ------------------------------
module gmcd_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] REV = 8'h5C; // Revision reply, arbitrary value
    localparam logic [1:0] DEV_TYPE = 2'h3; // Arbitrary value
    localparam logic [5:0] ID_PAT = 6'h2A; // Arbitrary value
    // Row: address, command, data, mask, command seen, write seen
    localparam logic [27:0] ROWS [13] = '{
        28'h8170A57, 28'h91465AB, 28'h89603CF, 28'h99C811F, 28'h8150427,
        28'h819A247, 28'h810E006, 28'h910400A, 28'h890200E, 28'h8100006,
        28'h8270A50, 28'h8101000, 28'h8070000};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [111:0] rd_data = 112'h0;
    logic [3:0] rd_len = 4'h1;
    wire dcl, fsc, dd, du_out, du_oe, cmd_strobe, wr_strobe, rd_req, busy;
    wire [7:0] cmd_opcode, wr_byte;
    wire [1:0] cmd_chan_mask;
    wire [3:0] wr_index;
    int mismatches = 0, num_checks = 0, n_cmd, n_wr, n_rd;
    logic [7:0] last_op, last_wr;
    logic [1:0] last_mask;
    logic [3:0] last_idx;
    logic [7:0] m [20]; // Message bytes in send order
    logic [27:0] r;
    always #5 ref_clk = ~ref_clk;
    gmcd_decoder #(.SLOT(0), .FRAME_BITS(32), .REVISION_CODE(REV), .DEVICE_TYPE(DEV_TYPE),
        .ID_PATTERN(ID_PAT)) gmcd_decoder_inst (.ref_clk(ref_clk), .rst_n(rst_n), .dcl(dcl),
        .fsc(fsc), .dd(dd), .du_out(du_out), .du_oe(du_oe), .cmd_strobe(cmd_strobe),
        .cmd_opcode(cmd_opcode), .cmd_chan_mask(cmd_chan_mask), .wr_strobe(wr_strobe),
        .wr_byte(wr_byte), .wr_index(wr_index), .rd_req(rd_req), .rd_data(rd_data),
        .rd_len(rd_len), .busy(busy));
    gmcd_host gmcd_host_inst (.dcl(dcl), .fsc(fsc), .dd(dd), .du_out(du_out), .du_oe(du_oe));
    // Record what the command side hands out
    always @(negedge ref_clk) begin
        if (cmd_strobe === 1'b1) begin
            n_cmd++;
            last_op = cmd_opcode;
            last_mask = cmd_chan_mask;
        end
        if (wr_strobe === 1'b1) begin
            n_wr++;
            last_wr = wr_byte;
            last_idx = wr_index;
        end
        if (rd_req === 1'b1)
            n_rd++;
    end
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Reset after a message lands at the last slot bit, inside the drive window
    task automatic do_reset;
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        check("oe", du_oe, 0);
        check("line", du_out, 1);
        check("busy", busy, 0);
        check("opcode", cmd_opcode, 0);
        rst_n = 1'b1;
    endtask
    task automatic send(input logic [7:0] a, input logic [7:0] c, input int n, input int idle);
        n_cmd = 0;
        n_wr = 0;
        n_rd = 0;
        gmcd_host_inst.up_q.delete();
        m[0] = a;
        m[1] = c;
        gmcd_host_inst.msg(m, n, idle);
    endtask
    // Every reply byte shows in two frames, then two idle frames
    task automatic check_up(input logic [7:0] e[$]);
        @(gmcd_host_inst.fstart); // Let the host finish the last idle frame
        check("reply length", gmcd_host_inst.up_q.size(), 2 * e.size());
        foreach (gmcd_host_inst.up_q[i])
            check("reply byte", gmcd_host_inst.up_q[i], e[i / 2]);
        check("end frames", gmcd_host_inst.eom_n >= 2, 1);
    endtask
    initial begin
        repeat (99000) @(posedge ref_clk);
        mismatches++;
        test_done();
    end
    initial begin
        do_reset();
        for (int i = 0; i < 13; i++) begin
            r = ROWS[i];
            m[2] = r[11:4];
            send(r[27:20], r[19:12], (r[11:4] != 8'h00) ? 3 : 2, 2);
            check("commands", n_cmd, r[1]);
            check("writes", n_wr, r[0]);
            check("reads", n_rd, 0);
            check("reply", gmcd_host_inst.up_q.size(), 0);
            if (r[1]) check("opcode", last_op, r[19:12]);
            if (r[1]) check("mask", last_mask, r[3:2]);
            if (r[0]) check("data", last_wr, r[11:4]);
        end
        send(8'h90, 8'h00, 2, 8);
        check("commands", n_cmd, 0);
        check_up('{8'h90, {DEV_TYPE, ID_PAT}});
        send(8'h80, 8'h00, 2, 8);
        check_up('{8'h80, {DEV_TYPE, ID_PAT}});
        @(negedge ref_clk);
        rd_len = 4'h3;
        rd_data[23:0] = 24'h332211;
        send(8'h89, 8'h71, 2, 10);
        check("reads", n_rd, 1);
        check_up('{8'h11, 8'h22, 8'h33});
        send(8'h81, 8'h73, 2, 6);
        check("side effects", n_rd + n_cmd, 0);
        check_up('{REV});
        for (int k = 0; k < 15; k++)
            m[k + 2] = 8'(k + 1);
        send(8'h81, 8'hC8, 17, 2);
        check("writes", n_wr, 14);
        check("index", last_idx, 4'hE);
        check("data", last_wr, 8'h0E);
        do_reset();
        test_done();
    end
endmodule // gmcd_decoder_test
bind gmcd_decoder gmcd_decoder_sva gmcd_decoder_sva_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .du_out(du_out), .du_oe(du_oe), .cmd_strobe(cmd_strobe), .cmd_opcode(cmd_opcode),
    .cmd_chan_mask(cmd_chan_mask), .wr_strobe(wr_strobe), .wr_index(wr_index),
    .rd_req(rd_req), .busy(busy));
`default_nettype wire
